// file: iscr_pkg.sv
package iscr_pkg;
   // register offsets
   localparam logic [7:0] ISCR_OFS_DRIVE = 8'h04;
   localparam logic [7:0] ISCR_OFS_CLK = 8'h05;
   localparam logic [7:0] ISCR_OFS_UTH_LO = 8'h06;
   localparam logic [7:0] ISCR_OFS_UTH_HI = 8'h07;
   localparam logic [7:0] ISCR_OFS_LTH_LO = 8'h08;
   localparam logic [7:0] ISCR_OFS_LTH_HI = 8'h09;
   localparam logic [7:0] ISCR_OFS_IRQ = 8'h0A;
   // reset values
   localparam logic [7:0] ISCR_RST_DRIVE = 8'h1B;
   localparam logic [7:0] ISCR_RST_CLK = 8'h01;
   localparam logic [7:0] ISCR_RST_UTH = 8'hFF;
   localparam logic [7:0] ISCR_RST_LTH = 8'h00;
   localparam logic [7:0] ISCR_RST_IRQ = 8'h00;
   // writable field masks, reserved bits read zero
   localparam logic [7:0] ISCR_MSK_DRIVE = 8'h1F;
   localparam logic [7:0] ISCR_MSK_CLK = 8'h03;
   localparam logic [7:0] ISCR_MSK_IRQ = 8'h07;
   // amplitude codes
   localparam logic [1:0] ISCR_AMP_1V = 2'h0;
   localparam logic [1:0] ISCR_AMP_2V = 2'h1;
   localparam logic [1:0] ISCR_AMP_4V = 2'h2;
   // conversion_window_sel in sensor periods per code
   localparam logic [12:0] ISCR_RT_192 = 13'h00C0;
   localparam logic [12:0] ISCR_RT_384 = 13'h0180;
   localparam logic [12:0] ISCR_RT_768 = 13'h0300;
   localparam logic [12:0] ISCR_RT_1536 = 13'h0600;
   localparam logic [12:0] ISCR_RT_3072 = 13'h0C00;
   localparam logic [12:0] ISCR_RT_6144 = 13'h1800;
   // interrupt pin functions
   typedef enum logic [2:0]
   {
      ISCR_FN_OFF = 3'h0,
      ISCR_FN_WAKE = 3'h1,
      ISCR_FN_COMP = 3'h2,
      ISCR_FN_CONVERSION_DONE = 3'h4
   } iscr_fn_t;
   // register write/read request
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iscr_req_t;
   // decoded configuration
   typedef struct packed
   {
      logic [1:0] amplitude;
      logic amp_valid;
      logic [12:0] conversion_window_sel;
      logic rt_valid;
      logic crystal_sel;
      logic oscillator_drive_off;
   } iscr_cfg_t;
endpackage

// file: iscr_regs.sv
// Function
// - amplitude code 00/01/10 gives 1/2/4 V
// - drive reset 1B, response 192..6144
// - clock select bit1: 0 ext, 1 crystal
// - bit0 disables crystal driver, reset 01
// - upper threshold bytes 06/07, reset FF
// - lower threshold bytes 08/09, reset 00
// - function 000 leaves interrupt pin idle
// - function 001 shows wake-up on pin
// - function 010 shows comparator on pin
// - function 100 shows data ready on pin
// - comparator 1 below low, 0 above high
// - wake-up active reads 0 above high
// - data ready reads 0 when new data
`timescale 1ns/1ps
module iscr_regs
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // register port from host interface
   input wire iscr_pkg::iscr_req_t i_req,
   output logic [7:0] o_rdata,
   // conversion side
   input wire logic [15:0] i_prox_data,
   input wire logic i_prox_valid,
   input wire logic i_data_read,
   // decoded configuration and status
   output iscr_pkg::iscr_cfg_t o_cfg,
   output logic o_comp_status,
   output logic o_wake_status_n,
   output logic o_conversion_done_n,
   // interrupt pin
   output logic o_interrupt_out_n
);
   import iscr_pkg::*;

   typedef struct packed
   {
      logic [7:0] drive;
      logic [7:0] clk;
      logic [7:0] uth_lo;
      logic [7:0] uth_hi;
      logic [7:0] lth_lo;
      logic [7:0] lth_hi;
      logic [7:0] irq;
      logic [7:0] rdata;
      logic comp;
      logic wake_n;
      logic conversion_done_n;
      logic pin_n;
      iscr_cfg_t cfg;
   } iscr_state_t;

   iscr_state_t st_r;
   iscr_state_t st_nxt;
   logic [15:0] uth;
   logic [15:0] lth;

   // threshold assembly
   assign uth = {st_r.uth_hi, st_r.uth_lo};
   assign lth = {st_r.lth_hi, st_r.lth_lo};

   // next state
   always_comb
   begin
      st_nxt = st_r;
      // register writes
      if (i_req.wr)
      begin
         unique case (i_req.addr)
            ISCR_OFS_DRIVE: st_nxt.drive = i_req.wdata & ISCR_MSK_DRIVE;
            ISCR_OFS_CLK: st_nxt.clk = i_req.wdata & ISCR_MSK_CLK;
            ISCR_OFS_UTH_LO: st_nxt.uth_lo = i_req.wdata;
            ISCR_OFS_UTH_HI: st_nxt.uth_hi = i_req.wdata;
            ISCR_OFS_LTH_LO: st_nxt.lth_lo = i_req.wdata;
            ISCR_OFS_LTH_HI: st_nxt.lth_hi = i_req.wdata;
            ISCR_OFS_IRQ: st_nxt.irq = i_req.wdata & ISCR_MSK_IRQ;
            default: st_nxt.irq = st_r.irq;
         endcase
      end
      // register reads, unmapped read zero
      if (i_req.rd)
      begin
         unique case (i_req.addr)
            ISCR_OFS_DRIVE: st_nxt.rdata = st_r.drive;
            ISCR_OFS_CLK: st_nxt.rdata = st_r.clk;
            ISCR_OFS_UTH_LO: st_nxt.rdata = st_r.uth_lo;
            ISCR_OFS_UTH_HI: st_nxt.rdata = st_r.uth_hi;
            ISCR_OFS_LTH_LO: st_nxt.rdata = st_r.lth_lo;
            ISCR_OFS_LTH_HI: st_nxt.rdata = st_r.lth_hi;
            ISCR_OFS_IRQ: st_nxt.rdata = st_r.irq;
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      // comparator with hysteresis
      if (i_prox_valid)
      begin
         if (i_prox_data < lth)
            st_nxt.comp = 1'b1;
         else if (i_prox_data > uth)
            st_nxt.comp = 1'b0;
         else
            st_nxt.comp = st_r.comp;
         if (i_prox_data > uth)
            st_nxt.wake_n = 1'b0;
         else
            st_nxt.wake_n = 1'b1;
      end
      // data ready: new result wins over read
      if (i_prox_valid)
         st_nxt.conversion_done_n = 1'b0;
      else if (i_data_read)
         st_nxt.conversion_done_n = 1'b1;
      // configuration decode
      st_nxt.cfg.amplitude = st_r.drive[4:3];
      st_nxt.cfg.amp_valid = (st_r.drive[4:3] != 2'h3);
      st_nxt.cfg.rt_valid = 1'b1;
      unique case (st_r.drive[2:0])
         3'h2: st_nxt.cfg.conversion_window_sel = ISCR_RT_192;
         3'h3: st_nxt.cfg.conversion_window_sel = ISCR_RT_384;
         3'h4: st_nxt.cfg.conversion_window_sel = ISCR_RT_768;
         3'h5: st_nxt.cfg.conversion_window_sel = ISCR_RT_1536;
         3'h6: st_nxt.cfg.conversion_window_sel = ISCR_RT_3072;
         3'h7: st_nxt.cfg.conversion_window_sel = ISCR_RT_6144;
         default:
         begin
            st_nxt.cfg.conversion_window_sel = ISCR_RT_192;
            st_nxt.cfg.rt_valid = 1'b0;
         end
      endcase
      st_nxt.cfg.crystal_sel = st_r.clk[1];
      st_nxt.cfg.oscillator_drive_off = st_r.clk[0];
      // interrupt pin function, active low
      unique case (st_r.irq[2:0])
         ISCR_FN_WAKE: st_nxt.pin_n = st_r.wake_n;
         ISCR_FN_COMP: st_nxt.pin_n = ~st_r.comp;
         ISCR_FN_CONVERSION_DONE: st_nxt.pin_n = st_r.conversion_done_n;
         default: st_nxt.pin_n = 1'b1;
      endcase
   end

   // state register
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st_r <= '0;
         st_r.drive <= ISCR_RST_DRIVE;
         st_r.clk <= ISCR_RST_CLK;
         st_r.uth_lo <= ISCR_RST_UTH;
         st_r.uth_hi <= ISCR_RST_UTH;
         st_r.lth_lo <= ISCR_RST_LTH;
         st_r.lth_hi <= ISCR_RST_LTH;
         st_r.irq <= ISCR_RST_IRQ;
         st_r.wake_n <= 1'b1;
         st_r.conversion_done_n <= 1'b1;
         st_r.pin_n <= 1'b1;
         // decode of reset code 1B: reserved amplitude, window 384
         st_r.cfg.amplitude <= ISCR_RST_DRIVE[4:3];
         st_r.cfg.amp_valid <= 1'b0;
         st_r.cfg.conversion_window_sel <= ISCR_RT_384;
         st_r.cfg.rt_valid <= 1'b1;
         st_r.cfg.oscillator_drive_off <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // outputs straight from state
   assign o_rdata = st_r.rdata;
   assign o_cfg = st_r.cfg;
   assign o_comp_status = st_r.comp;
   assign o_wake_status_n = st_r.wake_n;
   assign o_conversion_done_n = st_r.conversion_done_n;
   assign o_interrupt_out_n = st_r.pin_n;

   // checks
   pin_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.irq[2:0] == 3'h0) |=> o_interrupt_out_n)
      else $error("pin driven while function off");
   pin_wake_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.irq[2:0] == 3'h1) |=> (o_interrupt_out_n == $past(st_r.wake_n)))
      else $error("pin not following wake-up");
   pin_comp_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.irq[2:0] == 3'h2) |=> (o_interrupt_out_n == !$past(st_r.comp)))
      else $error("pin not following comparator");
   pin_conversion_done_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.irq[2:0] == 3'h4) |=> (o_interrupt_out_n == $past(st_r.conversion_done_n)))
      else $error("pin not following data ready");
   comp_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_prox_valid && i_prox_data < lth) |=> o_comp_status)
      else $error("comparator not set below low");
   comp_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_prox_valid && i_prox_data >= lth && i_prox_data <= uth) |=> $stable(o_comp_status))
      else $error("comparator changed inside band");
   wake_high_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_prox_valid && i_prox_data > uth) |=> !o_wake_status_n)
      else $error("wake-up missing above high");
   conversion_done_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_prox_valid |=> !o_conversion_done_n)
      else $error("data ready lost");
   clk_dec_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      1'b1 |=> (o_cfg.crystal_sel == $past(st_r.clk[1])
         && o_cfg.oscillator_drive_off == $past(st_r.clk[0])))
      else $error("clock config decode wrong");
   amp_dec_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.drive[4:3] == ISCR_AMP_2V) |=> (o_cfg.amplitude == ISCR_AMP_2V))
      else $error("amplitude decode wrong");
   rt_dec_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.drive[2:0] == 3'h7) |=> (o_cfg.conversion_window_sel == ISCR_RT_6144))
      else $error("conversion_window_sel decode wrong");
   uth_wr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_req.wr && i_req.addr == ISCR_OFS_UTH_HI) |=> (uth[15:8] == $past(i_req.wdata)))
      else $error("upper threshold write lost");
   lth_wr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_req.wr && i_req.addr == ISCR_OFS_LTH_LO) |=> (lth[7:0] == $past(i_req.wdata)))
      else $error("lower threshold write lost");

   cover_comp_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.irq[2:0] == 3'h2) ##1 !o_interrupt_out_n);
   cover_wake_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r.irq[2:0] == 3'h1) ##1 !o_interrupt_out_n);
   cover_conversion_done_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      !o_conversion_done_n ##1 i_data_read ##1 o_conversion_done_n);
endmodule // iscr_regs

// file: iscr_host.sv
`timescale 1ns/1ps
// host model: drives the register port at the falling edge
module iscr_host
(
   // clock
   input wire logic i_clk,
   // register port
   output iscr_pkg::iscr_req_t o_req,
   input wire logic [7:0] i_rdata
);
   import iscr_pkg::*;
   initial o_req = '0;
   // one-cycle write; callers use legal function codes except FA, which the mask cuts to 010, with
   // drive off set for an external clock, all while converting is off
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_req = '{1'b1, 1'b0, a, d};
      @(negedge i_clk);
      o_req = '0;
   endtask
   // one-cycle read, data taken one cycle after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge i_clk);
      o_req = '0;
      d = i_rdata;
   endtask
endmodule // iscr_host

// file: iscr_regs_test.sv
`timescale 1ns/1ps
module iscr_regs_test;
   import iscr_pkg::*;
   logic i_clk = 0, i_resetn = 0, i_prox_valid = 0, i_data_read = 0;
   logic [15:0] i_prox_data = 16'h0000;
   iscr_req_t req;
   iscr_cfg_t cfg;
   logic [7:0] rdata;
   logic comp, wake_n, done_n, pin;
   int fails = 0, n_compared = 0, cyc = 0;
   // clock
   initial forever #50 i_clk = ~i_clk;
   iscr_host i_iscr_host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));
   iscr_regs i_iscr_regs (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .o_rdata(rdata),
      .i_prox_data(i_prox_data), .i_prox_valid(i_prox_valid), .i_data_read(i_data_read),
      .o_cfg(cfg), .o_comp_status(comp), .o_wake_status_n(wake_n),
      .o_conversion_done_n(done_n), .o_interrupt_out_n(pin));
   // compare and count
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_iscr_host.rd(a, d);
      chk("rdata", {8'h00, e}, {8'h00, d});
   endtask
   // one conversion result, then let the pin settle
   task automatic conv(input logic [15:0] d);
      @(negedge i_clk);
      i_prox_data = d;
      i_prox_valid = 1;
      @(negedge i_clk);
      i_prox_valid = 0;
      @(negedge i_clk);
   endtask
   // reset values and unmapped read
   task automatic t_reset;
      chk("cfg", {2'h3, 13'h0180, 1'b1}, {cfg.amplitude, cfg.conversion_window_sel,
         cfg.oscillator_drive_off});
      chk("rstv", 16'h0001, {14'h0, cfg.amp_valid, cfg.rt_valid});
      chk("pins", 16'h0007, {comp, wake_n, done_n, pin});
      rchk(8'h04, 8'h1B);
      rchk(8'h05, 8'h01);
      rchk(8'h06, 8'hFF);
      rchk(8'h07, 8'hFF);
      rchk(8'h08, 8'h00);
      rchk(8'h09, 8'h00);
      rchk(8'h0A, 8'h00);
      rchk(8'h0B, 8'h00);
      $display("test reset done");
   endtask
   // every amplitude code, response codes 2..7 and reserved code 0, and masks
   task automatic t_fields;
      for (int a = 0; a < 3; a++)
         for (int r = 2; r < 8; r++)
         begin
            i_iscr_host.wr(8'h04, 8'(a * 8 + r));
            @(negedge i_clk);
            chk("amp", 16'(a * 2 + 1), {cfg.amplitude, cfg.amp_valid});
            chk("win", 16'(192 << (r - 2)), {3'h0, cfg.conversion_window_sel});
         end
      i_iscr_host.wr(8'h04, 8'h18);
      @(negedge i_clk);
      chk("rsvd", 16'h0000, {cfg.amp_valid, cfg.rt_valid});
      i_iscr_host.wr(8'h04, 8'hFF);
      rchk(8'h04, 8'h1F);
      i_iscr_host.wr(8'h05, 8'h02);
      @(negedge i_clk);
      chk("xtal", 16'h0002, {cfg.crystal_sel, cfg.oscillator_drive_off});
      i_iscr_host.wr(8'h05, 8'hFF);
      rchk(8'h05, 8'h03);
      i_iscr_host.wr(8'h05, 8'h01);
      @(negedge i_clk);
      chk("ext", 16'h0001, {cfg.crystal_sel, cfg.oscillator_drive_off});
      $display("test fields done");
   endtask
   // thresholds, hysteresis and comparator on the pin
   task automatic t_comp;
      i_iscr_host.wr(8'h06, 8'h34);
      i_iscr_host.wr(8'h07, 8'h12);
      i_iscr_host.wr(8'h09, 8'h01);
      i_iscr_host.wr(8'h0A, 8'hFA);
      rchk(8'h0A, 8'h02);
      conv(16'h00FF);
      chk("below", 16'h000C, {comp, wake_n, done_n, pin});
      conv(16'h1234);
      chk("between", 16'h000C, {comp, wake_n, done_n, pin});
      conv(16'h1235);
      chk("above", 16'h0001, {comp, wake_n, done_n, pin});
      $display("test comparator done");
   endtask
   // wake-up, data ready and off functions on the pin
   task automatic t_pin;
      i_iscr_host.wr(8'h0A, 8'h01);
      repeat (2) @(negedge i_clk);
      chk("wake", 16'h0000, {15'h0, pin});
      i_iscr_host.wr(8'h0A, 8'h04);
      repeat (2) @(negedge i_clk);
      chk("conversion_done", 16'h0000, {14'h0, done_n, pin});
      @(negedge i_clk);
      i_data_read = 1;
      @(negedge i_clk);
      i_data_read = 0;
      @(negedge i_clk);
      chk("read", 16'h0003, {14'h0, done_n, pin});
      conv(16'h0800);
      chk("new", 16'h0004, {13'h0, wake_n, done_n, pin});
      i_iscr_host.wr(8'h0A, 8'h00);
      repeat (2) @(negedge i_clk);
      chk("off", 16'h0001, {15'h0, pin});
      $display("test pin done");
   endtask
   // verdict
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         wrap_up();
      end
   end
   // main sequence
   initial
   begin
      repeat (20) @(negedge i_clk);
      i_resetn = 1;
      t_reset();
      t_fields();
      t_comp();
      t_pin();
      wrap_up();
   end
endmodule // iscr_regs_test
